// ### src/rrte_core.sv
// Executor for register, RAM-address and RAM transfer instructions
//
// Contract
// - B-to-A move copies B into the accumulator, B unchanged.
// - A-to-B move copies the accumulator into B, accumulator unchanged.
// - Y-to-A move copies Y into the accumulator, Y unchanged.
// - A-to-Y move copies the accumulator into Y, accumulator unchanged.
// - X-to-A move copies X into the accumulator, X unchanged.
// - Combine: E upper nibble gets B, lower nibble gets accumulator.
// - Split: B gets E upper nibble, accumulator gets E lower nibble.
// - A-to-D loads D from accumulator bits 2..0, bit 3 ignored.
// - D-to-A puts D in accumulator bits 2..0, bit 3 cleared.
// - Z-to-A puts Z in accumulator bits 1..0, bits 3..2 cleared.
// - Stack index to accumulator bits 2..0, bit 3 cleared.
// - Immediate X/Y load writes x field to X and y field to Y.
// - In a run of immediate X/Y loads only the first executes.
// - Immediate Z load writes the z field into Z.
// - Increment Y with wrap; skip next instruction when result is zero.
// - Decrement Y with wrap; skip next instruction when result is 15.
// - Memory read loads accumulator from RAM, then X becomes X xor j.
// - Memory exchange swaps accumulator and RAM word, then X becomes X xor j.
// - Exchange variants also step Y with the same skip-on-wrap behaviour.
// - Memory write stores accumulator to RAM, then X becomes X xor j.
`timescale 1ns/1ps
`default_nettype none
`include "rrte_consts.svh"

module rrte_core
  import rrte_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_instr_valid,
  input wire logic [`RRTE_INSTR_W-1:0] i_instr,
  input wire logic [2:0] i_stack_index,
  output logic o_instr_ready,
  output logic o_skipped,
  output logic o_skip_pend,
  output rrte_regs_t o_regs
);

  localparam rrte_state_t RST_STATE = '{phase: PH_FETCH, ready: 1'b1, mop: OP_NONE,
                                        default: '0};

  rrte_state_t st_r;
  rrte_state_t st_nxt;
  rrte_dec_t dec;
  logic drop;
  logic take;
  logic ram_we;
  logic [`RRTE_ADDR_W-1:0] ram_addr;
  logic [3:0] ram_wdata;
  logic [3:0] ram_rdata;
  logic [4:0] sy;

  // Returns {skip, new Y} for a step up or down
  function automatic logic [4:0] step_y(input logic [3:0] y, input logic down);
    logic [3:0] ny;
    ny = down ? 4'(y - 4'h1) : 4'(y + 4'h1);
    return {(ny == (down ? `RRTE_Y_DEC_WRAP : `RRTE_Y_INC_WRAP)), ny};
  endfunction : step_y

  rrte_decode u_decode (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  rrte_ram u_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(ram_we),
    .i_addr(ram_addr),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  assign drop = st_r.skip_pend | ((dec.op == OP_LOAD_XY) & st_r.last_xy);
  assign take = i_instr_valid & st_r.ready & ~drop;

  always_comb begin
    st_nxt = st_r;
    st_nxt.skipped = 1'b0;
    ram_we = 1'b0;
    ram_addr = {st_r.regs.z, st_r.regs.x, st_r.regs.y};
    ram_wdata = st_r.regs.acc;
    sy = 5'h00;
    case (st_r.phase)
      PH_FETCH: begin
        if (i_instr_valid) begin
          st_nxt.last_xy = (dec.op == OP_LOAD_XY);
          if (drop) begin
            st_nxt.skip_pend = 1'b0;
            st_nxt.skipped = 1'b1;
          end else begin
            case (dec.op)
              OP_B2A: st_nxt.regs.acc = st_r.regs.b;
              OP_A2B: st_nxt.regs.b = st_r.regs.acc;
              OP_Y2A: st_nxt.regs.acc = st_r.regs.y;
              OP_A2Y: st_nxt.regs.y = st_r.regs.acc;
              OP_JOIN_E: st_nxt.regs.e = {st_r.regs.b, st_r.regs.acc};
              OP_SPLIT_E: begin
                st_nxt.regs.b = st_r.regs.e[7:4];
                st_nxt.regs.acc = st_r.regs.e[3:0];
              end
              OP_A2D: st_nxt.regs.d = st_r.regs.acc[2:0];
              OP_D2A: st_nxt.regs.acc = {1'b0, st_r.regs.d};
              OP_Z2A: st_nxt.regs.acc = {2'b00, st_r.regs.z};
              OP_X2A: st_nxt.regs.acc = st_r.regs.x;
              OP_IDX2A: st_nxt.regs.acc = {1'b0, i_stack_index};
              OP_LOAD_XY: begin
                st_nxt.regs.x = dec.hi;
                st_nxt.regs.y = dec.lo;
              end
              OP_LOAD_Z: st_nxt.regs.z = dec.lo[1:0];
              OP_INC_Y: begin
                sy = step_y(st_r.regs.y, 1'b0);
                st_nxt.regs.y = sy[3:0];
                st_nxt.skip_pend = sy[4];
              end
              OP_DEC_Y: begin
                sy = step_y(st_r.regs.y, 1'b1);
                st_nxt.regs.y = sy[3:0];
                st_nxt.skip_pend = sy[4];
              end
              OP_MWR: begin
                ram_we = 1'b1;
                st_nxt.regs.x = st_r.regs.x ^ dec.lo;
              end
              OP_MRD, OP_MXCH, OP_MXCH_INC, OP_MXCH_DEC: begin
                st_nxt.phase = PH_MEM;
                st_nxt.addr = ram_addr;
                st_nxt.mop = dec.op;
                st_nxt.j = dec.lo;
              end
              default: st_nxt.phase = PH_FETCH;
            endcase
          end
        end
      end
      PH_MEM: begin
        ram_addr = st_r.addr;
        st_nxt.phase = PH_FETCH;
        st_nxt.regs.acc = ram_rdata;
        st_nxt.regs.x = st_r.regs.x ^ st_r.j;
        // exchange writes the old accumulator back
        ram_we = (st_r.mop != OP_MRD);
        if ((st_r.mop == OP_MXCH_INC) || (st_r.mop == OP_MXCH_DEC)) begin
          sy = step_y(st_r.regs.y, st_r.mop == OP_MXCH_DEC);
          st_nxt.regs.y = sy[3:0];
          st_nxt.skip_pend = sy[4];
        end
      end
      default: st_nxt.phase = PH_FETCH;
    endcase
    st_nxt.ready = (st_nxt.phase == PH_FETCH);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_instr_ready = st_r.ready;
  assign o_skipped = st_r.skipped;
  assign o_skip_pend = st_r.skip_pend;
  assign o_regs = st_r.regs;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  function automatic logic is_op(input rrte_op_t op, input rrte_op_t want);
    return op == want;
  endfunction : is_op

  b_to_acc_a: assert property (
    take && is_op(dec.op, OP_B2A) |=> o_regs.acc == $past(o_regs.b) && $stable(o_regs.b))
    else $error("B move did not reach accumulator");
  acc_to_b_a: assert property (
    take && is_op(dec.op, OP_A2B) |=> o_regs.b == $past(o_regs.acc) && $stable(o_regs.acc))
    else $error("Accumulator move did not reach B");
  y_to_acc_a: assert property (
    take && is_op(dec.op, OP_Y2A) |=> o_regs.acc == $past(o_regs.y) && $stable(o_regs.y))
    else $error("Y move did not reach accumulator");
  acc_to_y_a: assert property (
    take && is_op(dec.op, OP_A2Y) |=> o_regs.y == $past(o_regs.acc) && $stable(o_regs.acc))
    else $error("Accumulator move did not reach Y");
  x_to_acc_a: assert property (
    take && is_op(dec.op, OP_X2A) |=> o_regs.acc == $past(o_regs.x) && $stable(o_regs.x))
    else $error("X move did not reach accumulator");
  e_combine_a: assert property (
    take && is_op(dec.op, OP_JOIN_E) |=> o_regs.e == {$past(o_regs.b), $past(o_regs.acc)})
    else $error("E combine wrong");
  e_split_a: assert property (
    take && is_op(dec.op, OP_SPLIT_E)
      |=> {o_regs.b, o_regs.acc} == $past(o_regs.e))
    else $error("E split wrong");
  d_load_a: assert property (
    take && is_op(dec.op, OP_A2D) |=> o_regs.d == $past(o_regs.acc[2:0]))
    else $error("D load wrong");
  d_read_a: assert property (
    take && is_op(dec.op, OP_D2A) |=> o_regs.acc == {1'b0, $past(o_regs.d)})
    else $error("D read wrong");
  z_read_a: assert property (
    take && is_op(dec.op, OP_Z2A) |=> o_regs.acc == {2'b00, $past(o_regs.z)})
    else $error("Z read wrong");
  index_read_a: assert property (
    take && is_op(dec.op, OP_IDX2A) |=> o_regs.acc == {1'b0, $past(i_stack_index)})
    else $error("Stack index read wrong");
  xy_load_a: assert property (
    take && is_op(dec.op, OP_LOAD_XY) |=> {o_regs.x, o_regs.y} == $past(i_instr[7:0]))
    else $error("Immediate X/Y load wrong");
  xy_chain_a: assert property (
    take && is_op(dec.op, OP_LOAD_XY) ##1 i_instr_valid && is_op(dec.op, OP_LOAD_XY)
      |=> o_skipped && $stable(o_regs.x) && $stable(o_regs.y))
    else $error("Chained X/Y load executed");
  z_load_a: assert property (
    take && is_op(dec.op, OP_LOAD_Z) |=> o_regs.z == $past(i_instr[1:0]))
    else $error("Immediate Z load wrong");
  inc_skip_a: assert property (
    take && is_op(dec.op, OP_INC_Y)
      |=> o_regs.y == 4'($past(o_regs.y) + 4'h1) && o_skip_pend == (o_regs.y == 4'h0))
    else $error("Increment or its skip wrong");
  dec_skip_a: assert property (
    take && is_op(dec.op, OP_DEC_Y)
      |=> o_regs.y == 4'($past(o_regs.y) - 4'h1) && o_skip_pend == (o_regs.y == 4'hF))
    else $error("Decrement or its skip wrong");
  skip_drop_a: assert property (
    o_skip_pend && i_instr_valid && o_instr_ready |=> o_skipped && $stable(o_regs))
    else $error("Skipped instruction altered state");
  mem_read_a: assert property (
    take && is_op(dec.op, OP_MRD)
      |=> !o_instr_ready ##1 o_instr_ready && o_regs.acc == $past(ram_rdata)
      && o_regs.x == ($past(o_regs.x, 2) ^ $past(i_instr[3:0], 2)))
    else $error("Memory read wrong");
  mem_swap_a: assert property (
    st_r.phase == PH_MEM && st_r.mop != OP_MRD
      |-> ram_we && ram_wdata == o_regs.acc && ram_addr == st_r.addr)
    else $error("Exchange did not write back accumulator");
  swap_step_a: assert property (
    st_r.phase == PH_MEM && st_r.mop == OP_MXCH_INC
      |=> o_regs.y == 4'($past(o_regs.y) + 4'h1) && o_skip_pend == (o_regs.y == 4'h0))
    else $error("Exchange with increment wrong");
  mem_write_a: assert property (
    take && is_op(dec.op, OP_MWR)
      |-> ram_we && ram_wdata == o_regs.acc ##1 o_regs.x == ($past(o_regs.x) ^ $past(dec.lo)))
    else $error("Memory write wrong");
  mem_addr_a: assert property (
    take && dec.op inside {OP_MRD, OP_MXCH, OP_MXCH_INC, OP_MXCH_DEC}
      |=> st_r.addr == {$past(o_regs.z), $past(o_regs.x), $past(o_regs.y)})
    else $error("Memory address not taken before X update");

  // Memory reads and exchanges hold off the next word for one cycle
  mem_gap_a: assert property (
    take && dec.op inside {OP_MRD, OP_MXCH, OP_MXCH_INC, OP_MXCH_DEC}
      |=> !o_instr_ready && !o_skipped ##1 o_instr_ready)
    else $error("Memory transfer did not hold off one cycle");
  mem_xchg_a: assert property (
    take && is_op(dec.op, OP_MXCH)
      |=> !o_instr_ready ##1 o_instr_ready && o_regs.acc == $past(ram_rdata)
      && o_regs.x == ($past(o_regs.x, 2) ^ $past(i_instr[3:0], 2)))
    else $error("Memory exchange wrong");
  swap_down_a: assert property (
    st_r.phase == PH_MEM && st_r.mop == OP_MXCH_DEC
      |=> o_regs.y == 4'($past(o_regs.y) - 4'h1) && o_skip_pend == (o_regs.y == 4'hF))
    else $error("Exchange with decrement wrong");
  wr_addr_a: assert property (
    take && is_op(dec.op, OP_MWR) |-> ram_addr == {o_regs.z, o_regs.x, o_regs.y})
    else $error("Memory write address wrong");

  // A pending skip waits for the next word offered while ready, discards it, then clears
  skip_clear_a: assert property (
    o_skip_pend && i_instr_valid && o_instr_ready |=> !o_skip_pend)
    else $error("Skip not cleared by discarded word");
  skip_hold_a: assert property (
    o_skip_pend && !(i_instr_valid && o_instr_ready) |=> o_skip_pend)
    else $error("Pending skip lost while idle");

  cov_xy_chain_c: cover property (
    take && is_op(dec.op, OP_LOAD_XY) ##2 o_skipped ##1 o_skipped);
  cov_inc_wrap_c: cover property (take && is_op(dec.op, OP_INC_Y) ##1 o_skip_pend);
  cov_swap_dec_c: cover property (st_r.phase == PH_MEM && st_r.mop == OP_MXCH_DEC
                                  ##1 o_skip_pend);
  cov_read_c: cover property (take && is_op(dec.op, OP_MRD) ##2 o_instr_ready);
  cov_dec_wrap_c: cover property (take && is_op(dec.op, OP_DEC_Y) ##1 o_skip_pend);

endmodule : rrte_core

`default_nettype wire

// ### src/rrte_consts.svh
// Opcode patterns, field positions, widths and Y wrap values of the transfer executor
`ifndef RRTE_CONSTS_SVH
`define RRTE_CONSTS_SVH

`define RRTE_INSTR_W 10
`define RRTE_ADDR_W 10
`define RRTE_NIB_W 4

// Register moves
`define RRTE_OPC_B2A 10'h01E
`define RRTE_OPC_A2B 10'h00E
`define RRTE_OPC_Y2A 10'h01F
`define RRTE_OPC_A2Y 10'h00C
`define RRTE_OPC_JOIN_E 10'h01A
`define RRTE_OPC_SPLIT_E 10'h02A
`define RRTE_OPC_A2D 10'h029
`define RRTE_OPC_D2A 10'h051
`define RRTE_OPC_Z2A 10'h053
`define RRTE_OPC_X2A 10'h052
`define RRTE_OPC_IDX2A 10'h050

// RAM address operations
`define RRTE_OPC_LOAD_XY 10'h3??
`define RRTE_OPC_LOAD_Z 10'b0001_0010_??
`define RRTE_OPC_INC_Y 10'h013
`define RRTE_OPC_DEC_Y 10'h017

// RAM transfers, low nibble is the j field
`define RRTE_OPC_MRD 10'h2C?
`define RRTE_OPC_MXCH 10'h2D?
`define RRTE_OPC_MXCH_DEC 10'h2F?
`define RRTE_OPC_MXCH_INC 10'h2E?
`define RRTE_OPC_MWR 10'h2B?

// Immediate field positions
`define RRTE_HI_MSB 7
`define RRTE_HI_LSB 4
`define RRTE_LO_MSB 3
`define RRTE_LO_LSB 0

// Wrap values that trigger a skip
`define RRTE_Y_INC_WRAP 4'h0
`define RRTE_Y_DEC_WRAP 4'hF

`endif

// ### src/rrte_pkg.sv
// Types shared by the transfer executor modules
`include "rrte_consts.svh"

package rrte_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_B2A, OP_A2B, OP_Y2A, OP_A2Y, OP_JOIN_E, OP_SPLIT_E, OP_A2D, OP_D2A,
    OP_Z2A, OP_X2A, OP_IDX2A, OP_LOAD_XY, OP_LOAD_Z, OP_INC_Y, OP_DEC_Y,
    OP_MRD, OP_MXCH, OP_MXCH_INC, OP_MXCH_DEC, OP_MWR
  } rrte_op_t;

  typedef struct packed {
    rrte_op_t op;
    logic [3:0] hi;
    logic [3:0] lo;
  } rrte_dec_t;

  typedef enum logic {PH_FETCH, PH_MEM} rrte_phase_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
    logic [7:0] e;
    logic [2:0] d;
    logic [1:0] z;
    logic [3:0] x;
    logic [3:0] y;
  } rrte_regs_t;

  typedef struct packed {
    rrte_phase_t phase;
    logic ready;
    logic skip_pend;
    logic last_xy;
    logic skipped;
    rrte_regs_t regs;
    logic [`RRTE_ADDR_W-1:0] addr;
    rrte_op_t mop;
    logic [3:0] j;
  } rrte_state_t;

endpackage : rrte_pkg

// ### src/rrte_ram.sv
// Data RAM of 4-bit words with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rrte_consts.svh"

module rrte_ram
  import rrte_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [`RRTE_ADDR_W-1:0] i_addr,
  input wire logic [3:0] i_wdata,
  output logic [3:0] o_rdata
);

  logic [3:0] mem_r [0:(1<<`RRTE_ADDR_W)-1];

  // Read returns the word as it was before a write in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
    o_rdata <= mem_r[i_addr];
  end

endmodule : rrte_ram

`default_nettype wire

// ### src/rrte_decode.sv
// Instruction word decoder for the transfer instructions
`timescale 1ns/1ps
`default_nettype none
`include "rrte_consts.svh"

module rrte_decode
  import rrte_pkg::*;
(
  input wire logic [`RRTE_INSTR_W-1:0] i_instr,
  output rrte_dec_t o_dec
);

  always_comb begin
    o_dec.hi = i_instr[`RRTE_HI_MSB:`RRTE_HI_LSB];
    o_dec.lo = i_instr[`RRTE_LO_MSB:`RRTE_LO_LSB];
    casez (i_instr)
      `RRTE_OPC_B2A: o_dec.op = OP_B2A;
      `RRTE_OPC_A2B: o_dec.op = OP_A2B;
      `RRTE_OPC_Y2A: o_dec.op = OP_Y2A;
      `RRTE_OPC_A2Y: o_dec.op = OP_A2Y;
      `RRTE_OPC_JOIN_E: o_dec.op = OP_JOIN_E;
      `RRTE_OPC_SPLIT_E: o_dec.op = OP_SPLIT_E;
      `RRTE_OPC_A2D: o_dec.op = OP_A2D;
      `RRTE_OPC_D2A: o_dec.op = OP_D2A;
      `RRTE_OPC_Z2A: o_dec.op = OP_Z2A;
      `RRTE_OPC_X2A: o_dec.op = OP_X2A;
      `RRTE_OPC_IDX2A: o_dec.op = OP_IDX2A;
      `RRTE_OPC_LOAD_XY: o_dec.op = OP_LOAD_XY;
      `RRTE_OPC_LOAD_Z: o_dec.op = OP_LOAD_Z;
      `RRTE_OPC_INC_Y: o_dec.op = OP_INC_Y;
      `RRTE_OPC_DEC_Y: o_dec.op = OP_DEC_Y;
      `RRTE_OPC_MRD: o_dec.op = OP_MRD;
      `RRTE_OPC_MXCH: o_dec.op = OP_MXCH;
      `RRTE_OPC_MXCH_DEC: o_dec.op = OP_MXCH_DEC;
      `RRTE_OPC_MXCH_INC: o_dec.op = OP_MXCH_INC;
      `RRTE_OPC_MWR: o_dec.op = OP_MWR;
      default: o_dec.op = OP_NONE;
    endcase
  end

endmodule : rrte_decode

`default_nettype wire

// ### sim/rrte_prog_mem.sv
// Program memory model that offers queued instruction words to the executor
`timescale 1ns/1ps
`default_nettype none
`include "rrte_consts.svh"

module rrte_prog_mem (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_instr_ready,
  output logic o_instr_valid,
  output logic [`RRTE_INSTR_W-1:0] o_instr,
  output logic o_empty
);
  logic [`RRTE_INSTR_W-1:0] words[$];
  logic taken_r;

  initial begin
    o_instr_valid = 1'b0;
    o_instr = 10'h000;
    o_empty = 1'b1;
    taken_r = 1'b0;
  end

  task automatic load(input logic [`RRTE_INSTR_W-1:0] w);
    words.push_back(w);
  endtask : load

  always @(posedge i_clk_sys) begin
    taken_r <= i_rst_n & o_instr_valid & i_instr_ready;
  end

  // Word held until the edge that takes it; released lines toggle each cycle
  always @(negedge i_clk_sys) begin
    if (taken_r && words.size() > 0) begin
      words.delete(0);
    end
    if (words.size() > 0) begin
      o_instr_valid = 1'b1;
      o_instr = words[0];
    end else begin
      o_instr_valid = 1'b0;
      o_instr = ~o_instr;
    end
    o_empty = (words.size() == 0);
  end
endmodule : rrte_prog_mem
`default_nettype wire

// ### sim/rrte_core_tb_top.sv
// Self-checking bench for the transfer executor fed by the program memory model
`timescale 1ns/1ps
`default_nettype none
`include "rrte_consts.svh"

module rrte_core_tb_top
  import rrte_pkg::*;
;
  logic i_clk_sys;
  logic i_rst_n;
  logic instr_valid;
  logic [`RRTE_INSTR_W-1:0] instr;
  logic [2:0] stack_index;
  logic instr_ready;
  logic skipped;
  logic skip_pend;
  logic prog_empty;
  rrte_regs_t regs;
  rrte_regs_t er;
  logic [`RRTE_INSTR_W-1:0] q[$];
  int bad_count = 0;
  int n_checks = 0;
  int skips = 0;
  int exp_skips = 0;

  rrte_core i_rrte_core (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_instr_valid(instr_valid),
    .i_instr(instr),
    .i_stack_index(stack_index),
    .o_instr_ready(instr_ready),
    .o_skipped(skipped),
    .o_skip_pend(skip_pend),
    .o_regs(regs)
  );

  rrte_prog_mem i_rrte_prog_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_instr_ready(instr_ready),
    .o_instr_valid(instr_valid),
    .o_instr(instr),
    .o_empty(prog_empty)
  );

  initial i_clk_sys = 1'b0;
  always #5 i_clk_sys = ~i_clk_sys;

  // Each discard pulse lasts one cycle, so it is counted once
  always @(posedge i_clk_sys) begin
    if (skipped === 1'b1) begin
      skips <= skips + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chk_regs(input string nm);
    chk(nm, 32'(regs), 32'(er));
    chk("skips", 32'(skips), 32'(exp_skips));
    chk("skip pend", 32'(skip_pend), 32'h0);
  endtask : chk_regs

  // Hands the queued words to the model and waits, bounded, until all are taken
  task automatic run();
    int n;
    n = 0;
    foreach (q[k]) begin
      i_rrte_prog_mem.load(q[k]);
    end
    repeat (2) @(posedge i_clk_sys);
    while ((prog_empty !== 1'b1 || instr_valid !== 1'b0) && n < 200) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= 200) begin
      chk("drain", 32'h0, 32'h1);
    end
    repeat (3) @(negedge i_clk_sys);
  endtask : run

  task automatic t_reset();
    er = '{4'h0, 4'h0, 8'h00, 3'h0, 2'h0, 4'h0, 4'h0};
    chk_regs("reset regs");
    chk("ready", 32'(instr_ready), 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_moves();
    q = '{10'h3D9, 10'h01F, 10'h00E, 10'h052, 10'h029, 10'h01A, 10'h04B, 10'h053, 10'h00C};
    run();
    er = '{4'h3, 4'h9, 8'h9D, 3'h5, 2'h3, 4'hD, 4'h3};
    chk_regs("move regs");
    q = '{10'h00E, 10'h02A, 10'h051};
    run();
    er = '{4'h5, 4'h9, 8'h9D, 3'h5, 2'h3, 4'hD, 4'h3};
    chk_regs("split regs");
    stack_index = 3'h6;
    q = '{10'h050, 10'h00C, 10'h01E};
    run();
    er = '{4'h9, 4'h9, 8'h9D, 3'h5, 2'h3, 4'hD, 4'h6};
    chk_regs("index regs");
    $display("test moves done");
  endtask : t_moves

  task automatic t_xy_chain();
    q = '{10'h312, 10'h345, 10'h367};
    run();
    exp_skips = 2;
    er = '{4'h9, 4'h9, 8'h9D, 3'h5, 2'h3, 4'h1, 4'h2};
    chk_regs("chain regs");
    q = '{10'h389};
    run();
    exp_skips = 3;
    chk_regs("chain gap regs");
    q = '{10'h01F, 10'h3AB};
    run();
    er = '{4'h2, 4'h9, 8'h9D, 3'h5, 2'h3, 4'hA, 4'hB};
    chk_regs("chain break regs");
    $display("test xy chain done");
  endtask : t_xy_chain

  task automatic t_y_step();
    q = '{10'h01E, 10'h30F, 10'h013, 10'h01F};
    run();
    exp_skips = 4;
    er = '{4'h9, 4'h9, 8'h9D, 3'h5, 2'h3, 4'h0, 4'h0};
    chk_regs("inc wrap regs");
    q = '{10'h017, 10'h052};
    run();
    exp_skips = 5;
    er.y = 4'hF;
    chk_regs("dec wrap regs");
    q = '{10'h017, 10'h01F, 10'h013, 10'h052};
    run();
    er = '{4'h0, 4'h9, 8'h9D, 3'h5, 2'h3, 4'h0, 4'hF};
    chk_regs("no wrap regs");
    $display("test y step done");
  endtask : t_y_step

  task automatic t_memory();
    q = '{10'h049, 10'h323, 10'h01F, 10'h2B5, 10'h052, 10'h323, 10'h2CF};
    run();
    er = '{4'h3, 4'h9, 8'h9D, 3'h5, 2'h1, 4'hD, 4'h3};
    chk_regs("read regs");
    q = '{10'h052, 10'h323, 10'h2D1, 10'h323, 10'h2C0};
    run();
    er = '{4'hD, 4'h9, 8'h9D, 3'h5, 2'h1, 4'h2, 4'h3};
    chk_regs("exchange regs");
    q = '{10'h32F, 10'h2B0, 10'h052, 10'h32F, 10'h2E4, 10'h01E};
    run();
    exp_skips = 6;
    er = '{4'hD, 4'h9, 8'h9D, 3'h5, 2'h1, 4'h6, 4'h0};
    chk_regs("xchg inc regs");
    q = '{10'h320, 10'h2B0, 10'h052, 10'h320, 10'h2F1, 10'h01F};
    run();
    exp_skips = 7;
    er = '{4'hD, 4'h9, 8'h9D, 3'h5, 2'h1, 4'h3, 4'hF};
    chk_regs("xchg dec regs");
    $display("test memory done");
  endtask : t_memory

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    i_rst_n = 1'b0;
    stack_index = 3'h0;
    repeat (20) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    @(negedge i_clk_sys);
    t_reset();
    t_moves();
    t_xy_chain();
    t_y_step();
    t_memory();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    $display("unexpected watchdog: expected finish seen hang");
    stop_test();
  end
endmodule : rrte_core_tb_top
`default_nettype wire
